// file: mad_pkg.sv
package mad_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam logic [23:0] PROG_LAST = 24'h7fffff;
   localparam logic [23:0] REG_FIRST = 24'h800000;
   localparam logic [23:0] REG_LAST = 24'h80ffff;
   localparam logic [23:0] SRAM_FIRST = 24'h840000;
   localparam logic [23:0] SRAM_WIN_LAST = 24'h84ffff;
   localparam logic [23:0] SRAM_POP_END = 24'h844000;
   localparam int SPACE_BIT = 23;
   localparam int PERIPH_BIT = 18;
   localparam int TAG_BYTES = 256;
   localparam int LINE_BYTES = 2048;
   localparam logic [23:0] CACHE_BYTES = 24'h000900;
   localparam int LINE_SIZE = 16;
   localparam logic [23:0] CACHE_BASE_RST = 24'h840000;
   typedef enum logic [1:0] {
      MAD_TGT_FLASH = 2'h0,
      MAD_TGT_REG = 2'h1,
      MAD_TGT_SRAM = 2'h2,
      MAD_TGT_NONE = 2'h3
   } mad_tgt_e;
   typedef enum logic [1:0] {
      MAD_IDLE = 2'h0,
      MAD_LOOK = 2'h1,
      MAD_FILL = 2'h3,
      MAD_SERVE = 2'h2
   } mad_state_e;
endpackage

// file: mad_tag_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mad_tag_if #(parameter int AW = 4, parameter int DW = 16);
   logic we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: mad_tag_mem.sv
`timescale 1ns/1ns
`default_nettype none
module mad_tag_mem #(
   parameter int AW = 4,
   parameter int DW = 16
) (
   input wire logic clk,
   mad_tag_if.mem port
);
   logic [DW-1:0] mem_ff [0:(1<<AW)-1];
   logic [DW-1:0] rdata_ff;
   always_ff @(posedge clk) begin
      if (port.we) begin
         mem_ff[port.addr] <= port.wdata;
      end
   end
   always_ff @(posedge clk) begin
      rdata_ff <= port.we ? port.wdata : mem_ff[port.addr];
   end
   assign port.rdata = rdata_ff;
endmodule
`default_nettype wire

// file: mad_decoder.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Byte addresses are 24 bits wide, covering 16M bytes.
// - Bit 23 low selects program space, high selects peripheral space.
// - Program space spans 0 to 0x7fffff, served by flash.
// - Registers at 0x800000-0x80ffff, SRAM window 0x840000-0x84ffff.
// - In peripheral space bit 18 low picks registers, high picks SRAM.
// - Populated SRAM is 16 kB, from 0x840000 below 0x844000.
// - Cache uses 256 tag bytes plus 2048 code bytes, 0x900 total.
// - Cache base inside SRAM is programmable; its size is fixed.
// - Fetch hits serve from cache; misses fill from flash first.
// - SRAM keeps data and bss through retention and suspend.
module mad_decoder #(
   parameter int LINES = 128,
   parameter int LINE_B = mad_pkg::LINE_SIZE
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [23:0] cache_base,
   input wire logic cpu_req,
   input wire logic cpu_fetch,
   input wire logic cpu_we,
   input wire logic [23:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   output logic cpu_ack,
   output logic [31:0] cpu_rdata,
   output logic flash_req,
   output logic [23:0] flash_addr,
   input wire logic flash_ack,
   input wire logic [31:0] flash_rdata,
   output logic reg_req,
   output logic reg_we,
   output logic [15:0] reg_addr,
   output logic [31:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic [31:0] reg_rdata,
   output logic sram_req,
   output logic sram_we,
   output logic [13:0] sram_addr,
   output logic [31:0] sram_wdata,
   input wire logic sram_ack,
   input wire logic [31:0] sram_rdata
);
   localparam int IW = $clog2(LINES);
   localparam int OW = $clog2(LINE_B);
   localparam int TW = 24 - IW - OW;
   localparam int WPL = LINE_B / 4;

   if (LINES < 2 || LINES * LINE_B != mad_pkg::LINE_BYTES || LINE_B < 4 ||
       (1 << IW) != LINES || (1 << OW) != LINE_B) begin
      $error("Cache geometry must give 2048 code bytes in powers of two.");
   end

   function automatic mad_pkg::mad_tgt_e decode(input logic [23:0] a);
      if (!a[mad_pkg::SPACE_BIT]) begin
         decode = mad_pkg::MAD_TGT_FLASH;
      end else if (!a[mad_pkg::PERIPH_BIT]) begin
         decode = (a <= mad_pkg::REG_LAST) ? mad_pkg::MAD_TGT_REG
                  : mad_pkg::MAD_TGT_NONE;
      end else if (a >= mad_pkg::SRAM_FIRST && a < mad_pkg::SRAM_POP_END) begin
         decode = mad_pkg::MAD_TGT_SRAM;
      end else begin
         decode = mad_pkg::MAD_TGT_NONE;
      end
   endfunction

   mad_pkg::mad_state_e state_ff;
   logic [23:0] addr_ff;
   logic we_ff;
   logic [31:0] wdata_ff;
   logic fetch_ff;
   mad_pkg::mad_tgt_e tgt_ff;
   logic [LINES-1:0] valid_ff;
   logic [$clog2(WPL+1)-1:0] word_ff;
   logic sub_ff;
   logic busy_ack;
   logic [31:0] busy_data;

   mad_tag_if #(.AW(IW), .DW(TW)) tag_bus ();
   mad_tag_mem #(.AW(IW), .DW(TW)) u_tags (.clk(clk), .port(tag_bus));

   wire logic [IW-1:0] idx = addr_ff[OW +: IW];
   wire logic [TW-1:0] tag = addr_ff[23 -: TW];
   wire logic hit = valid_ff[idx] && (tag_bus.rdata == tag);
   // Cache code lines sit after the tag block at the programmable base.
   wire logic [23:0] line_base = cache_base + mad_pkg::CACHE_BYTES
                                 - 24'(mad_pkg::LINE_BYTES);
   wire logic [23:0] slot_addr = line_base + {{(24-IW-OW){1'b0}}, idx,
                                 {OW{1'b0}}};
   wire logic [23:0] word_off = 24'({word_ff, 2'b00});

   assign tag_bus.addr = (state_ff == mad_pkg::MAD_IDLE) ?
                         cpu_addr[OW +: IW] : idx;
   assign tag_bus.we = (state_ff == mad_pkg::MAD_FILL) &&
                       (word_ff == ($clog2(WPL+1))'(WPL));
   assign tag_bus.wdata = tag;

   // Flash fetches go through the cache; everything else passes straight on.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_ff <= mad_pkg::MAD_IDLE;
         addr_ff <= 24'h000000;
         we_ff <= 1'b0;
         wdata_ff <= 32'h00000000;
         fetch_ff <= 1'b0;
         tgt_ff <= mad_pkg::MAD_TGT_NONE;
         word_ff <= '0;
         sub_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            mad_pkg::MAD_IDLE: begin
               if (cpu_req) begin
                  addr_ff <= cpu_addr;
                  we_ff <= cpu_we;
                  wdata_ff <= cpu_wdata;
                  fetch_ff <= cpu_fetch;
                  tgt_ff <= decode(cpu_addr);
                  sub_ff <= 1'b0;
                  word_ff <= '0;
                  state_ff <= (cpu_fetch && decode(cpu_addr) ==
                               mad_pkg::MAD_TGT_FLASH) ? mad_pkg::MAD_LOOK
                              : mad_pkg::MAD_SERVE;
               end
            end
            mad_pkg::MAD_LOOK: begin
               state_ff <= hit ? mad_pkg::MAD_SERVE
                           : mad_pkg::MAD_FILL;
            end
            mad_pkg::MAD_FILL: begin
               // Each line word is read from flash, then written to SRAM.
               if (word_ff == ($clog2(WPL+1))'(WPL)) begin
                  state_ff <= mad_pkg::MAD_SERVE;
               end else if (!sub_ff && flash_ack) begin
                  sub_ff <= 1'b1;
                  wdata_ff <= flash_rdata;
               end else if (sub_ff && sram_ack) begin
                  sub_ff <= 1'b0;
                  word_ff <= word_ff + 1'b1;
               end
            end
            mad_pkg::MAD_SERVE: begin
               if (busy_ack) begin
                  state_ff <= mad_pkg::MAD_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         valid_ff <= '0;
      end else if (tag_bus.we) begin
         valid_ff[idx] <= 1'b1;
      end
   end

   wire logic cached = fetch_ff && tgt_ff == mad_pkg::MAD_TGT_FLASH;
   wire logic serve = state_ff == mad_pkg::MAD_SERVE;
   wire logic fill = state_ff == mad_pkg::MAD_FILL &&
                     word_ff != ($clog2(WPL+1))'(WPL);
   wire logic [23:0] sram_full = fill ? slot_addr + word_off
                     : cached ? slot_addr + 24'(addr_ff[OW-1:0])
                     : addr_ff;

   always_comb begin
      busy_ack = 1'b0;
      busy_data = 32'h00000000;
      if (serve) begin
         if (cached) begin
            busy_ack = sram_ack;
            busy_data = sram_rdata;
         end else begin
            unique case (tgt_ff)
               mad_pkg::MAD_TGT_FLASH: begin
                  busy_ack = flash_ack;
                  busy_data = flash_rdata;
               end
               mad_pkg::MAD_TGT_REG: begin
                  busy_ack = reg_ack;
                  busy_data = reg_rdata;
               end
               mad_pkg::MAD_TGT_SRAM: begin
                  busy_ack = sram_ack;
                  busy_data = sram_rdata;
               end
               mad_pkg::MAD_TGT_NONE: begin
                  busy_ack = 1'b1;
               end
            endcase
         end
      end
   end

   assign flash_req = (fill && !sub_ff) ||
                      (serve && !cached && tgt_ff == mad_pkg::MAD_TGT_FLASH);
   assign flash_addr = fill ? {addr_ff[23:OW], {OW{1'b0}}} + word_off
                       : addr_ff;
   assign reg_req = serve && tgt_ff == mad_pkg::MAD_TGT_REG;
   assign reg_we = we_ff;
   assign reg_addr = addr_ff[15:0];
   assign reg_wdata = wdata_ff;
   // SRAM holds its contents in every state; no clear is issued here.
   assign sram_req = (fill && sub_ff) ||
                     (serve && (cached ||
                      tgt_ff == mad_pkg::MAD_TGT_SRAM));
   assign sram_we = fill ? 1'b1 : (we_ff && !cached);
   assign sram_addr = sram_full[13:0];
   assign sram_wdata = wdata_ff;
   assign cpu_ack = busy_ack;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cpu_rdata <= 32'h00000000;
      end else if (busy_ack) begin
         cpu_rdata <= we_ff ? 32'h00000000 : busy_data;
      end
   end
endmodule
`default_nettype wire

// file: mad_tgt_model.sv
`timescale 1ns/1ns
`default_nettype none
module mad_tgt_model (
   input wire logic clk,
   input wire logic flash_req,
   input wire logic [23:0] flash_addr,
   output logic flash_ack,
   output logic [31:0] flash_rdata,
   input wire logic reg_req,
   input wire logic [15:0] reg_addr,
   output logic reg_ack,
   output logic [31:0] reg_rdata,
   input wire logic sram_req,
   input wire logic sram_we,
   input wire logic [13:0] sram_addr,
   input wire logic [31:0] sram_wdata,
   output logic sram_ack,
   output logic [31:0] sram_rdata
);
   logic [31:0] mem [0:4095];
   // Idle data lines show the inverse, so late sampling reads garbage.
   // The flash side only serves fills and loads, never commands.
   assign flash_rdata = {32{~flash_ack}} ^ {8'hc3, flash_addr};
   assign reg_rdata = {32{~reg_ack}} ^ {16'h5e00, reg_addr};
   assign sram_rdata = {32{~sram_ack}} ^ mem[sram_addr[13:2]];
   // Each target answers on the next edge or after a random stall.
   always @(posedge clk) begin
      flash_ack <= flash_req && !flash_ack && ($urandom_range(1) == 1);
      reg_ack <= reg_req && !reg_ack && ($urandom_range(1) == 1);
      sram_ack <= sram_req && !sram_ack && ($urandom_range(1) == 1);
      if (sram_req && sram_we && sram_ack) begin
         mem[sram_addr[13:2]] <= sram_wdata;
      end
   end
endmodule
`default_nettype wire

// file: mad_decoder_sva.sv
`timescale 1ns/1ns
`default_nettype none
module mad_dec_sva (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [23:0] cache_base,
   input wire logic cpu_req,
   input wire logic cpu_fetch,
   input wire logic cpu_we,
   input wire logic [23:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   input wire logic cpu_ack,
   input wire logic [31:0] cpu_rdata,
   input wire logic flash_req,
   input wire logic [23:0] flash_addr,
   input wire logic reg_req,
   input wire logic reg_we,
   input wire logic [31:0] reg_wdata,
   input wire logic [15:0] reg_addr,
   input wire logic reg_ack,
   input wire logic [31:0] reg_rdata,
   input wire logic sram_req,
   input wire logic [13:0] sram_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic hole;
   wire logic [23:0] sb;
   assign hole = cpu_addr[23] && cpu_addr[23:16] != 8'h80
      && cpu_addr[23:14] != 10'h210;
   assign sb = {10'h210, sram_addr};
   a_flash_prog: assert property (flash_req |-> !flash_addr[23]
      && !cpu_addr[23]) else $error("flash access outside program space");
   a_reg_window: assert property (reg_req |-> cpu_addr[23:16] == 8'h80
      && reg_addr == cpu_addr[15:0]) else $error("bad register decode");
   a_sram_select: assert property (sram_req && !cpu_fetch |->
      cpu_addr[23:14] == 10'h210 && sram_addr == cpu_addr[13:0])
      else $error("bad sram decode");
   a_reg_data_pass: assert property (reg_req && reg_ack && !reg_we
      |-> cpu_ack ##1 cpu_rdata == $past(reg_rdata))
      else $error("reg data lost");
   a_reg_wdata: assert property (reg_req && reg_we |->
      cpu_we && reg_wdata == cpu_wdata) else $error("reg write data lost");
   a_hole_quiet: assert property (cpu_req && hole |->
      !reg_req && !sram_req && !flash_req) else $error("hole reached target");
   a_hole_ack: assert property ($rose(cpu_req) && hole |=>
      cpu_ack ##1 cpu_rdata == 32'h0) else $error("hole answer wrong");
   a_cache_window: assert property (sram_req && cpu_fetch
      && !cpu_addr[23] |-> sb >= cache_base + 24'h100
      && sb < cache_base + 24'h900) else $error("cache slot outside region");
   a_fetch_done: assert property ($rose(cpu_req) && cpu_fetch |->
      ##[1:300] cpu_ack) else $error("fetch never completed");
endmodule
bind mad_decoder mad_dec_sva sva_u (.clk, .rst_b, .cache_base, .cpu_req,
   .cpu_fetch, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_ack, .cpu_rdata,
   .flash_req, .flash_addr, .reg_req, .reg_we, .reg_addr, .reg_wdata,
   .reg_ack, .reg_rdata, .sram_req, .sram_addr);
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk, rst_b, cpu_req, cpu_fetch, cpu_we, cpu_ack, flash_req;
   logic flash_ack, reg_req, reg_we, reg_ack, sram_req, sram_we, sram_ack;
   logic [23:0] cache_base, cpu_addr, flash_addr, a;
   logic [31:0] cpu_wdata, cpu_rdata, flash_rdata, reg_wdata, reg_rdata, d;
   logic [31:0] sram_wdata, sram_rdata;
   logic [15:0] reg_addr;
   logic [13:0] sram_addr;
   logic [31:0] exp_q[$];
   logic [23:0] holes[4] = '{24'h810000, 24'h83fffc, 24'h844000, 24'hfffffc};
   logic [23:0] offs[5] = '{24'h0, 24'h4, 24'h800, 24'h0, 24'hc};
   int n_mismatch = 0;
   int cmp_count = 0;
   mad_decoder dut_u (.clk, .rst_b, .cache_base, .cpu_req, .cpu_fetch,
      .cpu_we, .cpu_addr, .cpu_wdata, .cpu_ack, .cpu_rdata, .flash_req,
      .flash_addr, .flash_ack, .flash_rdata, .reg_req, .reg_we, .reg_addr,
      .reg_wdata, .reg_ack, .reg_rdata, .sram_req, .sram_we, .sram_addr,
      .sram_wdata, .sram_ack, .sram_rdata);
   mad_tgt_model tgt_u (.clk, .flash_req, .flash_addr, .flash_ack,
      .flash_rdata, .reg_req, .reg_addr, .reg_ack, .reg_rdata, .sram_req,
      .sram_we, .sram_addr, .sram_wdata, .sram_ack, .sram_rdata);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Read data lands the cycle after the completion pulse.
   initial forever begin
      @(posedge clk);
      if (cpu_ack === 1'b1) begin
         #1;
         check(cpu_rdata, exp_q.pop_front());
      end
   end
   task automatic acc(input logic f, input logic w, input logic [23:0] ad,
                      input logic [31:0] wd, input logic [31:0] e);
      int n;
      n = 0;
      exp_q.push_back(e);
      cpu_req <= 1'b1;
      cpu_fetch <= f;
      cpu_we <= w;
      cpu_addr <= ad;
      cpu_wdata <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (cpu_ack !== 1'b1 && n < 400);
      if (n >= 400) n_mismatch++;
      // Dropping the request for one edge lets the next one be seen new.
      cpu_req <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      #100000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'hdff0));
      {rst_b, cpu_req, cpu_fetch, cpu_we} = 4'h0;
      cpu_addr = 24'h0;
      cpu_wdata = 32'h0;
      cache_base = 24'h841000;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         a = i ? {1'b0, 23'($urandom)} & 24'h7ffffc : 24'h7ffffc;
         acc(0, 0, a, 0, {8'hc3, a});
         a = {8'h80, 16'($urandom)} & 24'hfffffc;
         d = $urandom;
         acc(0, 1, a, d, 0);
         acc(0, 0, a, 0, {16'h5e00, a[15:0]});
         a = i ? 24'h843000 | (24'($urandom) & 24'hffc) : 24'h843ffc;
         acc(0, 1, a, d, 0);
         acc(0, 0, a, 0, d);
         acc(1, 0, a, 0, d);
         acc(0, 1, holes[i], d, 0);
         acc(0, 0, holes[i], 0, 0);
      end
      for (int k = 0; k < 2; k++) begin
         rst_b <= 1'b0;
         cache_base <= k ? 24'h842400 : 24'h841000;
         repeat (5) @(posedge clk);
         rst_b <= 1'b1;
         @(posedge clk);
         a = {1'b0, 23'($urandom)} & 24'h7ff7f0;
         foreach (offs[j]) begin
            acc(1, 0, a + offs[j], 0, {8'hc3, a + offs[j]});
         end
      end
      repeat (3) @(posedge clk);
      print_verdict();
   end
endmodule
`default_nettype wire
